/* rtl/ebrt_map.svh */
`ifndef EBRT_MAP_SVH
`define EBRT_MAP_SVH

// register indices, byte address is four times the index
`define EBRT_IDX_MODE      16'hffc2
`define EBRT_IDX_COUNT     16'hffc3
`define EBRT_IDX_IRQ_STAT  16'hffd0
`define EBRT_IDX_IRQ_EN    16'hffd1
`define EBRT_IDX_EDGE      16'hffd2
`define EBRT_IDX_W         16
`define EBRT_ADDR_TOP      14'h0000

// mode register layout
`define EBRT_MODE_RESET    8'h78
`define EBRT_MODE_RSVD     8'h78
`define EBRT_MODE_RELOAD   7
`define EBRT_CSEL_HI       2
`define EBRT_CSEL_LO       0
`define EBRT_CSEL_RESET    3'h0
`define EBRT_CSEL_EXT      3'h7

// counter and reload
`define EBRT_COUNT_RESET   8'h00
`define EBRT_COUNT_MAX     8'hff
`define EBRT_COUNT_ONE     8'h01
`define EBRT_RELOAD_RESET  8'h00

// interrupt status, mask and edge select layout
`define EBRT_OVF_BIT       0
`define EBRT_EDGE_BIT      0
`define EBRT_PAD7          7'h00

// ahb
`define EBRT_HTRANS_ACT    1
`define EBRT_RDATA_RESET   32'h0000_0000
`define EBRT_PAD24         24'h00_0000

// prescaler taps, in counter bits
`define EBRT_DIV_W         13
`define EBRT_DIV_RESET     13'h0000
`define EBRT_DIV_ONE       13'h0001
`define EBRT_TAP_8192      13'h1fff
`define EBRT_TAP_2048      13'h07ff
`define EBRT_TAP_512       13'h01ff
`define EBRT_TAP_256       13'h00ff
`define EBRT_TAP_128       13'h007f
`define EBRT_TAP_32        13'h001f
`define EBRT_TAP_8         13'h0007
`define EBRT_SYNC_RESET    3'h7

`endif

/* rtl/ebrt_pkg.sv */
package ebrt_pkg;

   typedef enum logic {
      ebrt_bus_idle,
      ebrt_bus_write
   } ebrt_bus_t;

   typedef struct packed {
      ebrt_bus_t   bus;
      logic [15:0] widx;
      logic        reload_mode;
      logic [2:0]  clk_sel;
      logic [7:0]  count;
      logic [7:0]  reload;
      logic        ovf_flag;
      logic        ovf_en;
      logic        edge_rise;
      logic        irq;
      logic [31:0] rdata;
   } ebrt_state_t;

   typedef struct packed {
      logic [12:0] div;
      logic [2:0]  sync;
      logic        level;
      logic        tick;
   } ebrt_pre_t;

endpackage : ebrt_pkg

/* rtl/ebrt_prescaler.sv */
`timescale 1ns/100ps
`include "ebrt_map.svh"

module ebrt_prescaler
   import ebrt_pkg::*;
(
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // selection
   input  wire logic [2:0] clk_sel,
   input  wire logic       edge_rise,
   // event pin
   input  wire logic       event_input_pin,
   // count enable
   output logic            tick
);

   ebrt_pre_t p_q;
   ebrt_pre_t p_d;

   // all-ones mask of the divider bits that set the tap period
   function automatic logic [12:0] tap_mask(input logic [2:0] sel);
      case (sel)
         3'h0:    tap_mask = `EBRT_TAP_8192;
         3'h1:    tap_mask = `EBRT_TAP_2048;
         3'h2:    tap_mask = `EBRT_TAP_512;
         3'h3:    tap_mask = `EBRT_TAP_256;
         3'h4:    tap_mask = `EBRT_TAP_128;
         3'h5:    tap_mask = `EBRT_TAP_32;
         default: tap_mask = `EBRT_TAP_8;
      endcase
   endfunction : tap_mask

   function automatic logic tap_hit(input logic [12:0] div,
                                    input logic [2:0]  sel);
      tap_hit = ((div & tap_mask(sel)) == tap_mask(sel));
   endfunction : tap_hit

   always_comb begin
      p_d      = p_q;
      // free running, so the first tick after a select change varies
      p_d.div  = p_q.div + `EBRT_DIV_ONE;
      p_d.sync = {p_q.sync[1:0], event_input_pin}; // RULE17
      // level moves only once second and third stages agree
      if (p_q.sync[1] == p_q.sync[2]) begin
         p_d.level = p_q.sync[2];
      end
      if (clk_sel == `EBRT_CSEL_EXT) begin
         p_d.tick = edge_rise ? (p_d.level & ~p_q.level)
                              : (~p_d.level & p_q.level); // RULE4
      end else begin
         p_d.tick = tap_hit(p_q.div, clk_sel); // RULE3
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p_q <= {`EBRT_DIV_RESET, `EBRT_SYNC_RESET, 1'b1, 1'b0};
      end else begin
         p_q <= p_d;
      end
   end

   assign tick = p_q.tick;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_tap8_gap;
      (!tap_hit(p_q.div, 3'h6))[*7] ##1 tap_hit(p_q.div, 3'h6);
   endsequence

   a_tap_eight_gap: assert property ( // RULE3
      tap_hit(p_q.div, 3'h6) |=> s_tap8_gap)
      else $error("divide-by-8 tap period wrong");

   a_ext_rise_tick: assert property ( // RULE4
      (clk_sel == `EBRT_CSEL_EXT) && edge_rise && !p_q.level
      && p_q.sync[1] && p_q.sync[2] |=> tick)
      else $error("rising event edge gave no count");
endmodule : ebrt_prescaler

/* rtl/ebrt_timer.sv */
`timescale 1ns/100ps
`include "ebrt_map.svh"

// How it works
// RULE1: reload bit chooses interval or auto-reload
// RULE2: reserved mode bits read one, ignore writes
// RULE3: clock select picks seven taps or event
// RULE4: event edge polarity from edge select bit
// RULE5: reset clears counter, selects interval mode
// RULE6: readable 8-bit counter increments per tick
// RULE7: count past max sets overflow flag
// RULE8: interrupt only when flag and enable set
// RULE9: interval mode wraps to zero on overflow
// RULE10: reload write also loads counter at once
// RULE11: auto-reload overflow loads reload value
// RULE12: auto-reload period is 256 minus reload
// RULE13: counter read, reload write share address
// RULE14: reload register write-only, reset to zero
// RULE15: same clocks and interrupts in both modes
// RULE16: software routes pin, disables pin interrupt
// RULE17: event pin synchronised, edge becomes enable

module ebrt_timer
   import ebrt_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // interrupt
   output logic             irq,
   // event pin
   input  wire logic        event_input_pin
);

   ebrt_state_t st_q;
   ebrt_state_t st_d;
   logic        ready_q;
   logic        resp_q;
   logic        tick;
   logic        addr_ok;
   logic        take;
   logic [15:0] aidx;
   logic        wr_mode;
   logic        wr_count;
   logic        wr_stat;
   logic        wr_en;
   logic        wr_edge;
   logic        ovf;
   logic [7:0]  wbyte;

   // --------------------------------------------------------------
   // count clock: prescaler taps or synchronised event edges
   // --------------------------------------------------------------
   ebrt_prescaler u_pre (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .clk_sel         (st_q.clk_sel),
      .edge_rise       (st_q.edge_rise),
      .event_input_pin (event_input_pin),
      .tick            (tick)
   );

   // mode register image with reserved bits forced high
   function automatic logic [7:0] mode_image(input logic       rl,
                                             input logic [2:0] cs);
      logic [7:0] m;
      m = `EBRT_MODE_RSVD;
      m[`EBRT_MODE_RELOAD] = rl;
      m[`EBRT_CSEL_HI:`EBRT_CSEL_LO] = cs;
      mode_image = m; // RULE2
   endfunction : mode_image

   // --------------------------------------------------------------
   // address phase decode
   // --------------------------------------------------------------
   assign aidx    = haddr[`EBRT_IDX_W+1:2];
   assign addr_ok = (haddr[31:`EBRT_IDX_W+2] == `EBRT_ADDR_TOP);
   assign take    = hsel && htrans[`EBRT_HTRANS_ACT] && hready;

   // data phase write strobes, one per register
   assign wbyte    = hwdata[7:0];
   assign wr_mode  = (st_q.bus == ebrt_bus_write)
                     && (st_q.widx == `EBRT_IDX_MODE);
   assign wr_count = (st_q.bus == ebrt_bus_write)
                     && (st_q.widx == `EBRT_IDX_COUNT); // RULE13
   assign wr_stat  = (st_q.bus == ebrt_bus_write)
                     && (st_q.widx == `EBRT_IDX_IRQ_STAT);
   assign wr_en    = (st_q.bus == ebrt_bus_write)
                     && (st_q.widx == `EBRT_IDX_IRQ_EN);
   assign wr_edge  = (st_q.bus == ebrt_bus_write)
                     && (st_q.widx == `EBRT_IDX_EDGE);

   // overflow: a tick at the top count, unless a reload write wins
   assign ovf = tick && (st_q.count == `EBRT_COUNT_MAX)
                && !wr_count; // RULE7

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      st_d = st_q;

      // bus phase tracking; hsize is not checked, word access assumed
      st_d.bus  = ebrt_bus_idle;
      st_d.widx = st_q.widx;
      if (take && addr_ok && hwrite) begin
         st_d.bus  = ebrt_bus_write;
         st_d.widx = aidx;
      end

      // read data registered in the address phase
      st_d.rdata = st_q.rdata;
      if (take) begin
         st_d.rdata = `EBRT_RDATA_RESET;
         if (addr_ok && !hwrite) begin
            case (aidx)
               `EBRT_IDX_MODE: begin
                  st_d.rdata = {`EBRT_PAD24,
                     mode_image(st_q.reload_mode, st_q.clk_sel)}; // RULE2
               end
               `EBRT_IDX_COUNT: begin
                  st_d.rdata = {`EBRT_PAD24, st_q.count}; // RULE6 RULE13
               end
               `EBRT_IDX_IRQ_STAT: begin
                  st_d.rdata = {`EBRT_PAD24, `EBRT_PAD7, st_q.ovf_flag};
               end
               `EBRT_IDX_IRQ_EN: begin
                  st_d.rdata = {`EBRT_PAD24, `EBRT_PAD7, st_q.ovf_en};
               end
               `EBRT_IDX_EDGE: begin
                  st_d.rdata = {`EBRT_PAD24, `EBRT_PAD7, st_q.edge_rise};
               end
               default: begin
                  st_d.rdata = `EBRT_RDATA_RESET;
               end
            endcase
         end
      end

      // counting; both modes share the same clock and flag logic
      if (tick) begin // RULE15
         if (st_q.count == `EBRT_COUNT_MAX) begin
            if (st_q.reload_mode) begin
               st_d.count = st_q.reload; // RULE1 RULE11 RULE12
            end else begin
               st_d.count = `EBRT_COUNT_RESET; // RULE1 RULE9
            end
         end else begin
            st_d.count = st_q.count + `EBRT_COUNT_ONE; // RULE6
         end
      end

      // mode write; reserved bits are dropped
      if (wr_mode) begin
         st_d.reload_mode = wbyte[`EBRT_MODE_RELOAD]; // RULE1 RULE2
         st_d.clk_sel     = wbyte[`EBRT_CSEL_HI:`EBRT_CSEL_LO]; // RULE3
      end

      // reload write loads the counter too, and beats a same-cycle tick
      if (wr_count) begin
         st_d.reload = wbyte; // RULE14
         st_d.count  = wbyte; // RULE10
      end

      // sticky flag, write one to clear; a new overflow wins
      st_d.ovf_flag = ovf
                      || (st_q.ovf_flag
                          && !(wr_stat && wbyte[`EBRT_OVF_BIT])); // RULE7

      if (wr_en) begin
         st_d.ovf_en = wbyte[`EBRT_OVF_BIT];
      end
      if (wr_edge) begin
         st_d.edge_rise = wbyte[`EBRT_EDGE_BIT]; // RULE4
      end

      // level interrupt follows the next flag and enable
      st_d.irq = st_d.ovf_flag && st_d.ovf_en; // RULE8
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '{
            bus:         ebrt_bus_idle,
            widx:        `EBRT_IDX_MODE,
            reload_mode: 1'b0,
            clk_sel:     `EBRT_CSEL_RESET,
            count:       `EBRT_COUNT_RESET,
            reload:      `EBRT_RELOAD_RESET,
            ovf_flag:    1'b0,
            ovf_en:      1'b0,
            edge_rise:   1'b0,
            irq:         1'b0,
            rdata:       `EBRT_RDATA_RESET
         }; // RULE5 RULE14
         ready_q <= 1'b1;
         resp_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         // zero wait states, every access completes in one data phase
         ready_q <= 1'b1;
         resp_q  <= 1'b0;
      end
   end

   assign hrdata    = st_q.rdata;
   assign hreadyout = ready_q;
   assign hresp     = resp_q;
   assign irq       = st_q.irq;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_read_mode;
      take && addr_ok && !hwrite && (aidx == `EBRT_IDX_MODE);
   endsequence

   sequence s_top_tick;
      tick && (st_q.count == `EBRT_COUNT_MAX) && !wr_count;
   endsequence

   a_rsvd_read_ones: assert property ( // RULE2
      s_read_mode |=> (hrdata[6:3] == 4'hf) && (hrdata[31:8] == 24'h0))
      else $error("reserved mode bits not read as one");

   a_rsvd_write_drop: assert property ( // RULE2
      wr_mode |=> (st_q.clk_sel == $past(hwdata[2:0]))
                  && (st_q.reload_mode == $past(hwdata[7])))
      else $error("mode write not taken as expected");

   a_count_step: assert property ( // RULE6
      tick && !wr_count && (st_q.count != `EBRT_COUNT_MAX)
      |=> st_q.count == $past(st_q.count) + 8'h01)
      else $error("counter did not step by one");

   a_count_hold: assert property ( // RULE6
      !tick && !wr_count |=> $stable(st_q.count))
      else $error("counter moved without a tick");

   a_ovf_sets_flag: assert property ( // RULE7
      s_top_tick |=> st_q.ovf_flag ##1 (st_q.ovf_flag || $past(wr_stat)))
      else $error("overflow did not set the flag");

   a_irq_gate: assert property ( // RULE8
      st_q.ovf_flag && st_q.ovf_en |-> irq ##0 !(irq && !st_q.ovf_en))
      else $error("interrupt output wrong for flag and enable");

   a_irq_low_masked: assert property ( // RULE8
      !st_q.ovf_en |-> !irq)
      else $error("interrupt raised while disabled");

   a_wrap_zero: assert property ( // RULE9
      (s_top_tick and !st_q.reload_mode) |=> st_q.count == 8'h00)
      else $error("interval mode did not wrap to zero");

   a_reload_load: assert property ( // RULE10
      wr_count |=> (st_q.count == $past(hwdata[7:0]))
                   && (st_q.reload == $past(hwdata[7:0])))
      else $error("reload write did not load counter");

   a_auto_reload: assert property ( // RULE11
      (s_top_tick and st_q.reload_mode) |=> st_q.count == $past(st_q.reload))
      else $error("auto-reload did not load reload value");

   a_shared_read: assert property ( // RULE13
      take && addr_ok && !hwrite && (aidx == `EBRT_IDX_COUNT)
      |=> hrdata == {24'h0, $past(st_q.count)})
      else $error("count address did not return the counter");

   a_ready_always: assert property (
      hreadyout && !hresp)
      else $error("slave not ready or erroring");

   a_reset_values: assert property ( // RULE5 RULE14
      $rose(hresetn) |-> (st_q.count == `EBRT_COUNT_RESET)
      && (st_q.reload == `EBRT_RELOAD_RESET) && !st_q.reload_mode)
      else $error("state not cleared by reset");

   a_mode_read_back: assert property ( // RULE1 RULE3
      s_read_mode |=> (hrdata[`EBRT_MODE_RELOAD] == $past(st_q.reload_mode))
      && (hrdata[`EBRT_CSEL_HI:`EBRT_CSEL_LO] == $past(st_q.clk_sel)))
      else $error("mode read does not show mode and select");

   a_irq_flag_low: assert property ( // RULE8
      !st_q.ovf_flag |-> !irq)
      else $error("interrupt raised without flag");

   sequence s_clear_write;
      wr_stat && wbyte[`EBRT_OVF_BIT] && !ovf;
   endsequence

   a_flag_w1c_clear: assert property ( // RULE7
      s_clear_write |=> !st_q.ovf_flag)
      else $error("write one did not clear the flag");

   a_flag_sticky: assert property ( // RULE7
      st_q.ovf_flag && !wr_stat |=> st_q.ovf_flag)
      else $error("flag dropped without a clear");

   a_flag_no_set: assert property ( // RULE7
      !st_q.ovf_flag && !ovf |=> !st_q.ovf_flag)
      else $error("flag set without overflow");

   a_reload_hold: assert property ( // RULE14
      !wr_count |=> $stable(st_q.reload))
      else $error("reload changed without a write");

   // the select seen by a tick is the one of the cycle before it
   a_tick_single: assert property ( // RULE17
      tick && (st_q.clk_sel == `EBRT_CSEL_EXT) |=> !tick)
      else $error("one event edge gave two counts");

   a_ovf_irq_edge: assert property ( // RULE8 RULE15
      (s_top_tick and (st_q.ovf_en && !wr_en)) |=> irq)
      else $error("enabled overflow gave no interrupt");

   a_mode_hold: assert property ( // RULE1 RULE3
      !wr_mode |=> $stable(st_q.clk_sel) && $stable(st_q.reload_mode))
      else $error("mode changed without a write");

   a_edge_sel_write: assert property ( // RULE4
      wr_edge |=> st_q.edge_rise == $past(hwdata[`EBRT_EDGE_BIT]))
      else $error("edge select write not taken");

endmodule : ebrt_timer

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`include "ebrt_map.svh"

module tb_top
   import ebrt_pkg::*;
;
   // clock and reset
   logic        hclk;
   logic        hresetn;
   // bus
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         hresp;
   // interrupt and pin
   wire         irq;
   logic        event_input_pin;
   // bookkeeping
   int          error_cnt;
   int          tests_run;
   logic [31:0] rd;
   logic        rsp;
   logic [7:0]  c0;
   int          taps [7] = '{8192, 2048, 512, 256, 128, 32, 8};

   ebrt_timer i_dut (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hreadyout),
      .hrdata          (hrdata),
      .hreadyout       (hreadyout),
      .hresp           (hresp),
      .irq             (irq),
      .event_input_pin (event_input_pin)
   );

   always #10 hclk = ~hclk;

   task test_done;
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // bounded wait: a stuck slave must not hang the run
   task wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 50) begin
         n++;
         @(posedge hclk);
      end
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t: bus never ready", $time);
         test_done;
      end
   endtask : wait_rdy

   task ahb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {`EBRT_ADDR_TOP, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      wait_rdy;
      rd = hrdata;
      rsp = hresp;
   endtask : ahb

   task wr(input logic [15:0] idx, input logic [7:0] wd);
      ahb(1'b1, idx, wd);
   endtask : wr

   task rdchk(input logic [15:0] idx, input logic [7:0] exp);
      ahb(1'b0, idx, 8'h00);
      chk(rd, {24'h00_0000, exp});
      chk({31'h0000_0000, rsp}, 32'h0000_0000);
   endtask : rdchk

   task irqchk(input logic exp);
      repeat (2) @(posedge hclk);
      chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
   endtask : irqchk

   // n low then high excursions of the event pin
   task pulse(input int n);
      repeat (n) begin
         event_input_pin <= 1'b0;
         repeat (10) @(posedge hclk);
         event_input_pin <= 1'b1;
         repeat (10) @(posedge hclk);
      end
   endtask : pulse

   task edge_step(input logic rise, input logic [7:0] base);
      wr(`EBRT_IDX_EDGE, {7'h00, rise});
      event_input_pin <= 1'b0;
      repeat (10) @(posedge hclk);
      rdchk(`EBRT_IDX_COUNT, base + {7'h00, ~rise});
      event_input_pin <= 1'b1;
      repeat (10) @(posedge hclk);
      rdchk(`EBRT_IDX_COUNT, base + 8'h01);
   endtask : edge_step

   initial begin
      hclk            = 1'b0;
      hresetn         = 1'b0;
      hsel            = 1'b0;
      haddr           = 32'h0000_0000;
      htrans          = 2'h0;
      hwrite          = 1'b0;
      hsize           = 3'h2;
      hwdata          = 32'h0000_0000;
      event_input_pin = 1'b1;
      error_cnt       = 0;
      tests_run       = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;

      rdchk(`EBRT_IDX_MODE, 8'h78);
      rdchk(`EBRT_IDX_COUNT, 8'h00);
      rdchk(`EBRT_IDX_IRQ_STAT, 8'h00);
      rdchk(`EBRT_IDX_IRQ_EN, 8'h00);
      rdchk(`EBRT_IDX_EDGE, 8'h00);
      irqchk(1'b0);
      wr(16'hffc0, 8'hff);
      rdchk(16'hffc0, 8'h00);
      $display("test reset done");

      wr(`EBRT_IDX_MODE, 8'h00);
      rdchk(`EBRT_IDX_MODE, 8'h78);
      wr(`EBRT_IDX_MODE, 8'h87);
      rdchk(`EBRT_IDX_MODE, 8'hff);
      $display("test mode done");

      // reload still holds its reset value here
      pulse(255);
      rdchk(`EBRT_IDX_COUNT, 8'hff);
      rdchk(`EBRT_IDX_IRQ_STAT, 8'h00);
      pulse(1);
      rdchk(`EBRT_IDX_COUNT, 8'h00);
      rdchk(`EBRT_IDX_IRQ_STAT, 8'h01);
      wr(`EBRT_IDX_IRQ_STAT, 8'h01);
      rdchk(`EBRT_IDX_IRQ_STAT, 8'h00);
      $display("test period 256 done");

      wr(`EBRT_IDX_MODE, 8'h07);
      wr(`EBRT_IDX_COUNT, 8'h40);
      rdchk(`EBRT_IDX_COUNT, 8'h40);
      edge_step(1'b0, 8'h40);
      edge_step(1'b1, 8'h41);
      $display("test edges done");

      wr(`EBRT_IDX_COUNT, 8'hfe);
      pulse(1);
      rdchk(`EBRT_IDX_COUNT, 8'hff);
      pulse(1);
      rdchk(`EBRT_IDX_COUNT, 8'h00);
      rdchk(`EBRT_IDX_IRQ_STAT, 8'h01);
      irqchk(1'b0);
      wr(`EBRT_IDX_IRQ_EN, 8'h01);
      irqchk(1'b1);
      wr(`EBRT_IDX_IRQ_EN, 8'h00);
      irqchk(1'b0);
      wr(`EBRT_IDX_IRQ_EN, 8'h01);
      wr(`EBRT_IDX_IRQ_STAT, 8'h01);
      rdchk(`EBRT_IDX_IRQ_STAT, 8'h00);
      irqchk(1'b0);
      $display("test interval done");

      wr(`EBRT_IDX_MODE, 8'h87);
      wr(`EBRT_IDX_COUNT, 8'hfd);
      rdchk(`EBRT_IDX_COUNT, 8'hfd);
      pulse(2);
      rdchk(`EBRT_IDX_IRQ_STAT, 8'h00);
      pulse(1);
      rdchk(`EBRT_IDX_COUNT, 8'hfd);
      irqchk(1'b1);
      wr(`EBRT_IDX_IRQ_STAT, 8'h01);
      wr(`EBRT_IDX_COUNT, 8'hff);
      pulse(1);
      rdchk(`EBRT_IDX_COUNT, 8'hff);
      rdchk(`EBRT_IDX_IRQ_STAT, 8'h01);
      wr(`EBRT_IDX_IRQ_STAT, 8'h01);
      wr(`EBRT_IDX_IRQ_EN, 8'h00);
      $display("test auto reload done");

      // two tick periods between samples taken exactly 2*n edges apart
      for (int s = 0; s < 7; s++) begin
         wr(`EBRT_IDX_MODE, s[7:0]);
         repeat (4) @(posedge hclk);
         ahb(1'b0, `EBRT_IDX_COUNT, 8'h00);
         c0 = rd[7:0];
         repeat (2 * taps[s] - 3) @(posedge hclk);
         ahb(1'b0, `EBRT_IDX_COUNT, 8'h00);
         chk({24'h00_0000, rd[7:0] - c0}, 32'h0000_0002);
      end
      $display("test taps done");
      test_done;
   end

endmodule : tb_top
